/* File: shared/tape_port_regs.vh */
// Constants for the drive-side host command port of a tape drive.
// Assumes a single 20 MHz core clock and host pins arriving asynchronously.
//
// Functional notes
// - Two unit lines decode to unit 0..3.
// - Respond only when unit matches switch setting.
// - Idle host may reselect; selected drive shows status.
// - Four op lines, first is most significant.
// - Codes 0-3: nop, clear, diag, sense.
// - Codes 4-7: read fwd, read back, write, loop.
// - Codes 8-B: file/block back, file/block forward.
// - Codes C-F: mark, erase, rewind, rewind unload.
// - Fixed panel density used for write at BOT.
// - Panel host mode: 00 low, 01 high density.
// - Density changes only on write at BOT.
// - Write: request asks byte, answer means valid.
// - Read: request means byte valid, answer taken.
// - Request held until acknowledge or terminate.
// - Terminate on read stops further bytes.
// - Terminate on block pulse stops spacing; the code stops block spacing only, file spacing ignores it.
// - Busy drops only after positioning completes.
// - Busy set on accept, held until done.
`ifndef TAPE_PORT_REGS_VH
`define TAPE_PORT_REGS_VH

// Operation codes
`define OP_NOP         4'h0
`define OP_CLEAR       4'h1
`define OP_DIAG_SET    4'h2
`define OP_SENSE       4'h3
`define OP_READ_FWD    4'h4
`define OP_READ_BACK   4'h5
`define OP_WRITE       4'h6
`define OP_LOOP_WR     4'h7
`define OP_BACK_FILE   4'h8
`define OP_BACK_BLOCK  4'h9
`define OP_FWD_FILE    4'hA
`define OP_FWD_BLOCK   4'hB
`define OP_WRITE_MARK  4'hC
`define OP_ERASE_GAP   4'hD
`define OP_REWIND      4'hE
`define OP_REWIND_UNLOAD 4'hF

// Density encodings (host lines and resolved value)
`define DENS_1600      2'h0
`define DENS_6250      2'h1

// Front-panel density switch modes
`define PANEL_1600     2'h0
`define PANEL_6250     2'h1
`define PANEL_HOST     2'h2

// Timing
`define CLK_PERIOD_NS  50
`define BLOCK_PULSE_NS 400
`define BLOCK_PULSE_CYC ((`BLOCK_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Reset values
`define UNIT_RESET     2'h0
`define BYTE_RESET     8'h00

`endif

/* File: logic/tape_pin_sync.v */
// Two-flop synchroniser for a group of asynchronous pin levels.
// Assumes each bit is an independent level; no bus coherence implied.
module tape_pin_sync
#(
   parameter W = 1
)
(
   input  wire         core_clk,
   input  wire         rstn,
   input  wire [W-1:0] pin_in,
   output reg  [W-1:0] pin_sync
);

   // First stage, read only by the second stage
   reg [W-1:0] stage1;

   // Both stages reset to zero, the deasserted level
   always @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         stage1   <= {W{1'b0}};
         pin_sync <= {W{1'b0}};
      end
      else
      begin
         stage1   <= pin_in;
         pin_sync <= stage1;
      end
   end

endmodule

/* File: logic/tape_byte_buffer.v */
// Two-entry valid/ready buffer between host bytes and the formatter.
// Assumes both sides on core_clk; in_ready falls only when both slots fill.
module tape_byte_buffer
#(
   parameter W = 9
)
(
   input  wire         core_clk,
   input  wire         rstn,
   input  wire         in_valid,
   output wire         in_ready,
   input  wire [W-1:0] in_data,
   output wire         out_valid,
   input  wire         out_ready,
   output wire [W-1:0] out_data
);

   reg [W-1:0] slot [0:1];   // Storage, indexed by pointer
   reg         wr_ptr;       // Next slot to fill
   reg         rd_ptr;       // Next slot to drain
   reg [1:0]   count;        // Occupied slots

   wire push = in_valid & in_ready;
   wire pop  = out_valid & out_ready;

   assign in_ready  = (count != 2'h2);
   assign out_valid = (count != 2'h0);
   assign out_data  = slot[rd_ptr];

   // Pointer and occupancy update; push and pop may coincide
   always @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         wr_ptr  <= 1'b0;
         rd_ptr  <= 1'b0;
         count   <= 2'h0;
         slot[0] <= {W{1'b0}};
         slot[1] <= {W{1'b0}};
      end
      else
      begin
         if (push)
         begin
            slot[wr_ptr] <= in_data;
            wr_ptr       <= ~wr_ptr;
         end
         if (pop)
            rd_ptr <= ~rd_ptr;
         if (push && !pop)
            count <= count + 2'h1;
         else if (pop && !push)
            count <= count - 2'h1;
      end
   end

endmodule

/* File: logic/tape_host_port.v */
// Drive-side host command port: selection, command decode, density,
// byte handshake and terminate handling.
// Assumes host pins are asynchronous; engine signals share core_clk.
`include "tape_port_regs.vh"

module tape_host_port
(
   input  wire       core_clk,
   input  wire       rstn,
   // Host pins, all active high after receiver inversion
   input  wire       unit_select_low,
   input  wire       unit_select_high,
   input  wire       op_code_bit3,
   input  wire       op_code_bit2,
   input  wire       op_code_bit1,
   input  wire       op_code_bit0,
   input  wire       density_code_low,
   input  wire       density_code_high,
   input  wire       start,
   input  wire       byte_acknowledge,
   input  wire       terminate,
   input  wire [7:0] data_in,
   output reg  [7:0] data_out,
   output wire       data_oe,
   output reg        byte_request,
   output reg        busy,
   output reg        block_sensed,
   output wire       status_select,
   // Drive configuration
   input  wire [1:0] unit_switch,
   input  wire [1:0] panel_density,
   // Tape engine side
   input  wire       at_bot,
   input  wire [1:0] id_density,
   output reg        cmd_strobe,
   output reg  [3:0] cmd_code,
   output reg  [1:0] cmd_density,
   output reg        cmd_set_density,
   output reg        term_req,
   input  wire       engine_done,
   input  wire       block_found,
   input  wire       rd_valid,
   output wire       rd_ready,
   input  wire [7:0] rd_data,
   output wire       wr_valid,
   input  wire       wr_ready,
   output wire [7:0] wr_data,
   output wire       wr_last
);

   // One-hot states
   localparam [5:0] S_IDLE   = 6'h01;
   localparam [5:0] S_LAUNCH = 6'h02;
   localparam [5:0] S_REQ    = 6'h04;
   localparam [5:0] S_HOLD   = 6'h08;
   localparam [5:0] S_SPACE  = 6'h10;
   localparam [5:0] S_DRAIN  = 6'h20;

   localparam [31:0] BLK_CYC_W = `BLOCK_PULSE_CYC;  // Block pulse length, full width
   localparam [3:0]  BLK_CYC   = BLK_CYC_W[3:0];    // Cut to counter width on purpose

   reg  [5:0] state;          // Handshake sequencer
   reg        start_prev;     // Start level one cycle back
   reg        stopped;        // Terminate seen in this transfer
   reg        done_seen;      // Engine finished, held until the next accept
   reg  [3:0] blk_cnt;        // Block pulse stretcher
   reg        unit_pad;       // Switch sampled after release
   reg  [1:0] unit_id;        // This drive's address

   // Synchronised pin groups
   wire [1:0] unit_s;
   wire [3:0] op_s;
   wire [1:0] dens_s;
   wire       start_s;
   wire       ack_s;
   wire       stop_s;
   wire [7:0] din_s;
   wire [1:0] sw_s;

   // All host levels pass two flops before any logic reads them
   tape_pin_sync #(.W(21)) u_pin_sync
   (
      .core_clk (core_clk),
      .rstn     (rstn),
      .pin_in   ({unit_select_high, unit_select_low,
                  op_code_bit3, op_code_bit2, op_code_bit1, op_code_bit0,
                  density_code_high, density_code_low,
                  start, byte_acknowledge, terminate, data_in, unit_switch}),
      .pin_sync ({unit_s, op_s, dens_s, start_s, ack_s, stop_s, din_s, sw_s})
   );

   // Switch is caught by a clocked process after reset release
   always @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         unit_pad <= 1'b0;
         unit_id  <= `UNIT_RESET;
      end
      else
      begin
         unit_pad <= 1'b1;
         if (!busy)
            unit_id <= sw_s;    // Follows switch only between commands
      end
   end

   // High line is the upper bit of the unit number
   wire [1:0] unit_sel = unit_s;
   wire       match    = unit_pad && (unit_sel == unit_id);

   // Selected drive offers its status lines; reselect allowed while idle
   assign status_select = match;

   // First op line is the most significant code bit
   wire [3:0] op_now = op_s;

   // Command classes from the captured code
   wire is_read  = (cmd_code == `OP_READ_FWD) ||
                   (cmd_code == `OP_READ_BACK);
   wire is_write = (cmd_code == `OP_WRITE) ||
                   (cmd_code == `OP_LOOP_WR);
   wire is_space = (cmd_code == `OP_BACK_BLOCK) ||
                   (cmd_code == `OP_FWD_BLOCK);

   // Density resolution; only host code 01 means the high density
   wire [1:0] host_dens = (dens_s == `DENS_6250) ? `DENS_6250 : `DENS_1600;
   wire       op_is_wr  = (op_now == `OP_WRITE) || (op_now == `OP_LOOP_WR);
   reg  [1:0] next_dens;
   reg        next_set;

   // Choose density for the command being accepted
   always @*
   begin
      next_dens = id_density;
      next_set  = 1'b0;
      if (op_is_wr && at_bot)
      begin
         next_set = 1'b1;
         case (panel_density)
            `PANEL_1600: next_dens = `DENS_1600;
            `PANEL_6250: next_dens = `DENS_6250;
            `PANEL_HOST: next_dens = host_dens;
            default:     next_dens = id_density;
         endcase
      end
   end

   // Accept only a fresh start edge at the addressed, idle drive
   wire start_rise = start_s && !start_prev;
   wire accept     = (state == S_IDLE) && start_rise && match && !busy;

   // Host answer to a pending request
   wire answer = byte_request && (ack_s || stop_s);
   wire in_req = (state == S_REQ);

   // Write path: answered byte goes into the buffer, last marked by stop
   wire       buf_in_ready;
   wire       buf_push = in_req && answer && is_write;
   wire [8:0] buf_out;

   // Two-entry buffer toward the formatter so a stall loses no byte
   tape_byte_buffer #(.W(9)) u_wr_buf
   (
      .core_clk  (core_clk),
      .rstn      (rstn),
      .in_valid  (buf_push),
      .in_ready  (buf_in_ready),
      .in_data   ({stop_s, din_s}),
      .out_valid (wr_valid),
      .out_ready (wr_ready),
      .out_data  (buf_out)
   );

   assign wr_data = buf_out[7:0];
   assign wr_last = buf_out[8];

   // Read path: byte taken from deformatter once host answers
   assign rd_ready = in_req && answer && is_read;

   // Drive the data bus for the whole of a read command
   assign data_oe = busy && is_read;

   // Data can be offered or requested in this cycle
   wire can_go = is_write ? buf_in_ready : rd_valid;

   // Command and handshake sequencer
   always @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state           <= S_IDLE;
         start_prev      <= 1'b0;
         busy            <= 1'b0;
         byte_request    <= 1'b0;
         stopped         <= 1'b0;
         term_req        <= 1'b0;
         cmd_strobe      <= 1'b0;
         cmd_code        <= `OP_NOP;
         cmd_density     <= `DENS_1600;
         cmd_set_density <= 1'b0;
         data_out        <= `BYTE_RESET;
         done_seen       <= 1'b0;
      end
      else
      begin
         start_prev <= start_s;
         cmd_strobe <= 1'b0;
         // Completion is sticky so no state can miss it
         if (engine_done)
            done_seen <= 1'b1;
         case (state)
            S_IDLE:
            begin
               if (accept)
               begin
                  // Lines captured here and held for the operation
                  cmd_code        <= op_now;
                  cmd_density     <= next_dens;
                  cmd_set_density <= next_set;
                  cmd_strobe      <= 1'b1;
                  busy            <= 1'b1;
                  stopped         <= 1'b0;
                  done_seen       <= 1'b0;
                  state           <= S_LAUNCH;
               end
            end
            S_LAUNCH:
            begin
               // Route by command class
               if (is_read || is_write)
                  state <= S_REQ;
               else if (is_space)
                  state <= S_SPACE;
               else
                  state <= S_DRAIN;
            end
            S_REQ:
            begin
               if (!byte_request)
               begin
                  if (done_seen)
                  begin
                     // Engine ended the block itself
                     busy  <= 1'b0;
                     state <= S_IDLE;
                  end
                  else if (can_go)
                  begin
                     byte_request <= 1'b1;
                     if (is_read)
                        data_out <= rd_data;
                  end
               end
               else if (ack_s || stop_s)
               begin
                  // Request drops only after an answer
                  byte_request <= 1'b0;
                  if (stop_s)
                  begin
                     stopped  <= 1'b1;
                     term_req <= 1'b1;
                  end
                  state <= S_HOLD;
               end
            end
            S_HOLD:
            begin
               // Wait for the host to release its answer
               if (!ack_s && !stop_s)
                  state <= stopped ? S_DRAIN : S_REQ;
            end
            S_SPACE:
            begin
               if (stop_s)
               begin
                  term_req <= 1'b1;
                  state    <= S_DRAIN;
               end
               else if (done_seen)
               begin
                  busy  <= 1'b0;
                  state <= S_IDLE;
               end
            end
            S_DRAIN:
            begin
               // Busy holds until the engine has positioned the tape
               if (done_seen)
               begin
                  busy     <= 1'b0;
                  term_req <= 1'b0;
                  state    <= S_IDLE;
               end
            end
            default:
            begin
               state        <= S_IDLE;
               busy         <= 1'b0;
               byte_request <= 1'b0;
               term_req     <= 1'b0;
            end
         endcase
      end
   end

   // Stretch the engine's block pulse to its nominal width;
   // a retrigger restarts the count, so close pulses merge into one
   always @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         blk_cnt      <= 4'h0;
         block_sensed <= 1'b0;
      end
      else if (block_found && busy)
      begin
         blk_cnt      <= BLK_CYC;
         block_sensed <= 1'b1;
      end
      else if (blk_cnt > 4'h1)
         blk_cnt <= blk_cnt - 4'h1;
      else
      begin
         blk_cnt      <= 4'h0;
         block_sensed <= 1'b0;
      end
   end

endmodule

/* File: bench/tape_host_port_sva.sv */
// Concurrent checks on the host command port, bound to its top module.
// Assumes one core clock; host pins reach the port through synchronisers.
module tape_host_port_sva
(
   input wire       core_clk,
   input wire       rstn,
   input wire       byte_acknowledge,
   input wire       terminate,
   input wire       engine_done,
   input wire [7:0] data_out,
   input wire       byte_request,
   input wire       busy,
   input wire       block_sensed,
   input wire       status_select,
   input wire       cmd_strobe,
   input wire [3:0] cmd_code,
   input wire [1:0] cmd_density
);
   timeunit 1ns;
   timeprecision 1ps;
   reg done_seen;   // Engine finished since the last accept

   // Completion memory; busy may only fall once it is set
   always @(posedge core_clk or negedge rstn)
      if (!rstn)
         done_seen <= 1'b0;
      else if (cmd_strobe)
         done_seen <= 1'b0;
      else if (engine_done)
         done_seen <= 1'b1;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);

   // Block pulse: eight cycles high, then low
   sequence block_pulse;
      block_sensed [*8] ##1 !block_sensed;
   endsequence

   a_strobe_raises_busy: assert property (cmd_strobe |-> $rose(busy))
      else $error("strobe without busy rising");
   a_busy_needs_strobe: assert property ($rose(busy) |-> cmd_strobe)
      else $error("busy rose without a strobe");
   a_strobe_when_selected: assert property (cmd_strobe |-> status_select)
      else $error("strobe while another unit is addressed");
   a_request_held_answer: assert property
      ($fell(byte_request) |-> $past(byte_acknowledge) || $past(terminate))
      else $error("request dropped without an answer");
   a_read_byte_stable: assert property
      (byte_request && $past(byte_request) |-> $stable(data_out))
      else $error("read byte changed under a request");
   a_block_pulse_len: assert property ($rose(block_sensed) |-> block_pulse)
      else $error("block pulse not eight cycles");
   a_op_held_busy: assert property
      (busy && !cmd_strobe |-> $stable(cmd_code) && $stable(cmd_density))
      else $error("captured command changed while busy");
   a_busy_after_done: assert property ($fell(busy) |-> done_seen)
      else $error("busy fell before the engine finished");
endmodule

bind tape_host_port tape_host_port_sva chk
(
   .core_clk, .rstn, .byte_acknowledge, .terminate, .engine_done, .data_out,
   .byte_request, .busy, .block_sensed, .status_select, .cmd_strobe, .cmd_code,
   .cmd_density
);

/* File: bench/host_model.sv */
// Host controller model driving the drive's command and handshake pins.
// Assumes the bench calls its tasks at falling edges of the core clock.
module host_model
(
   input  wire logic       core_clk,
   input  wire logic       busy,
   input  wire logic       byte_request,
   input  wire logic [7:0] data_out,
   output logic      [1:0] unit,
   output logic      [3:0] op,
   output logic      [1:0] dens,
   output logic            start,
   output logic            ack,
   output logic            term,
   output logic      [7:0] data
);
   timeunit 1ns;
   timeprecision 1ps;

   // Quiet pins from time zero
   initial
      {unit, op, dens, start, ack, term, data} = '0;

   // Lines set a cycle ahead of start, kept until the next command
   task automatic issue(input logic [7:0] uod, output bit ok);
      @(negedge core_clk);
      {unit, op, dens} = uod;
      @(negedge core_clk);
      start = 1'b1;
      repeat (12) if (!busy) @(negedge core_clk);
      ok = busy;
      start = 1'b0;
   endtask

   // One answer per request, held until the request drops
   task automatic answer(input logic [7:0] v, input bit last, output logic [7:0] got,
                         output bit ok);
      repeat (300) if (!byte_request) @(negedge core_clk);
      ok = byte_request;
      got = data_out;
      data = v;
      @(negedge core_clk);
      {term, ack} = {last, !last};
      repeat (20) if (byte_request) @(negedge core_clk);
      ok = ok && !byte_request;
      {term, ack} = 2'b00;
      data = ~v;   // Released bus shows the inverse, never a stale byte
   endtask
endmodule

/* File: bench/tape_host_port_test.sv */
// Self-checking bench for the host command port; the bench is the tape engine.
// Assumes host_model drives the host pins and the checker is bound.
`include "tape_port_regs.vh"
module tape_host_port_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk, rstn, at_bot, engine_done, block_found, rd_valid, wr_ready, stall;
   logic [1:0]  unit_switch, panel_density, id_density;
   logic [7:0]  rd_data;
   logic [15:0] rnd, wr_rnd;
   wire         unit_select_low, unit_select_high, op_code_bit3, op_code_bit2;
   wire         op_code_bit1, op_code_bit0, density_code_low, density_code_high, start;
   wire         byte_acknowledge, terminate, data_oe, byte_request, busy, block_sensed;
   wire         status_select, cmd_strobe, cmd_set_density, term_req, rd_ready;
   wire         wr_valid, wr_last;
   wire  [7:0]  data_in, data_out, wr_data;
   wire  [3:0]  cmd_code;
   wire  [1:0]  cmd_density;
   int          n_mismatch, n_tests;
   bit          ok;
   logic [8:0]  wq[$];   // Write words seen leaving, last flag on top

   tape_host_port DUT
   (
      .core_clk, .rstn, .unit_select_low, .unit_select_high, .op_code_bit3, .op_code_bit2,
      .op_code_bit1, .op_code_bit0, .density_code_low, .density_code_high, .start,
      .byte_acknowledge, .terminate, .data_in, .data_out, .data_oe, .byte_request, .busy,
      .block_sensed, .status_select, .unit_switch, .panel_density, .at_bot, .id_density,
      .cmd_strobe, .cmd_code, .cmd_density, .cmd_set_density, .term_req, .engine_done,
      .block_found, .rd_valid, .rd_ready, .rd_data, .wr_valid, .wr_ready, .wr_data, .wr_last
   );

   host_model host
   (
      .core_clk, .busy, .byte_request, .data_out, .start, .data(data_in),
      .unit({unit_select_high, unit_select_low}),
      .op({op_code_bit3, op_code_bit2, op_code_bit1, op_code_bit0}),
      .dens({density_code_high, density_code_low}), .ack(byte_acknowledge), .term(terminate)
   );

   // Pseudo-random source
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // Density a write at tape start should use
   function automatic logic [1:0] dens_exp(input logic [1:0] pnl, input logic [1:0] hc,
                                           input logic [1:0] idd);
      case (pnl)
         `PANEL_1600: return `DENS_1600;
         `PANEL_6250: return `DENS_6250;
         `PANEL_HOST: return (hc == 2'h1) ? `DENS_6250 : `DENS_1600;
         default:     return idd;
      endcase
   endfunction

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic ans(input logic [7:0] v, input bit last, output logic [7:0] got);
      host.answer(v, last, got, ok);
      check("answered", ok, 1);
   endtask

   // Engine side of one command, then completion
   task automatic traffic(input logic [3:0] o);
      logic [7:0] v[3];
      logic [7:0] gv;
      v = '{rnd[7:0], rnd[15:8], rnd[11:4]};
      wq.delete();
      if (o == `OP_WRITE || o == `OP_LOOP_WR)
      begin
         ans(v[0], 0, gv);
         ans(v[1], 0, gv);
         repeat (20) @(negedge core_clk);
         check("request", byte_request, !stall);
         stall = 1'b0;
         ans(v[2], 1, gv);
         repeat (20) @(negedge core_clk);
         for (int i = 0; i < 3; i++)
            check("word", 16'(wq[i]), {7'h00, i == 2, v[i]});
      end
      else if (o == `OP_READ_FWD || o == `OP_READ_BACK)
         fork
            for (int i = 0; i < 3; i++)
            begin
               ans(v[i], i == 2, gv);
               check("read byte", gv, v[i]);
            end
            begin
               rd_valid = 1'b1;
               foreach (v[i])
               begin
                  rd_data = v[i];
                  repeat (300) if (!rd_ready) @(negedge core_clk);
                  @(negedge core_clk);
               end
               rd_data = ~v[0];   // A further byte waits after the stop
            end
         join
      else if (o == `OP_BACK_BLOCK || o == `OP_FWD_BLOCK)
      begin
         block_found = 1'b1;
         @(negedge core_clk);
         block_found = 1'b0;
         repeat (10) if (!block_sensed) @(negedge core_clk);
         check("block pulse", block_sensed, 1);
         host.term = 1'b1;
         repeat (6) @(negedge core_clk);
         host.term = 1'b0;
      end
      else
      begin   // A second start while busy must be ignored
         @(negedge core_clk);
         host.start = 1'b1;
         repeat (6) @(negedge core_clk);
         host.start = 1'b0;
      end
      repeat (10) @(negedge core_clk);
      check("no request", byte_request, 0);
      check("stop seen", term_req, o inside {[4'h4:4'h7], 4'h9, 4'hB});
      check("busy held", busy, 1);
      check("op held", cmd_code, o);
      check("bus driven", data_oe, o inside {4'h4, 4'h5});
      engine_done = 1'b1;
      @(negedge core_clk);
      engine_done = 1'b0;
      rd_valid = 1'b0;
      repeat (20) if (busy) @(negedge core_clk);
      check("busy end", busy, 0);
   endtask

   // Clock at 20 MHz
   initial
   begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   // Write sink: random stalls unless a scenario holds it off
   always @(negedge core_clk)
   begin
      wr_rnd = lfsr(wr_rnd);
      wr_ready <= !stall && (wr_rnd[0] || wr_rnd[1]);
   end

   // Collects each word the write stream hands over
   always @(posedge core_clk)
      if (wr_valid && wr_ready)
         wq.push_back({wr_last, wr_data});

   // Cuts a hang short
   initial
   begin
      repeat (60000) @(posedge core_clk);
      n_mismatch++;
      summarize();
   end

   initial
   begin
      {rstn, at_bot, engine_done, block_found, rd_valid, stall, wr_ready} = '0;
      {panel_density, id_density, rd_data} = '0;
      unit_switch = 2'h2;
      rnd = 16'h1F9F;
      wr_rnd = 16'h1F9F;
      repeat (6) @(negedge core_clk);
      rstn = 1'b1;
      repeat (4) @(negedge core_clk);
      for (int u = 0; u < 4; u++)
      begin
         host.unit = 2'(u);
         repeat (4) @(negedge core_clk);
         check("selected", status_select, u == 2);
      end
      host.issue({2'h1, `OP_NOP, 2'h0}, ok);
      check("foreign unit", ok, 0);
      // Every op code, then writes at tape start over each panel setting
      for (int i = 0; i < 24; i++)
      begin
         logic [3:0] o;
         logic [1:0] hc;
         logic [1:0] de;
         rnd = lfsr(rnd);
         o = (i < 16) ? 4'(i) : `OP_WRITE;
         hc = (i < 16) ? rnd[7:6] : {1'b0, i[2]};
         at_bot = rnd[0] || i >= 16;
         id_density = {1'b0, rnd[1]};
         panel_density = (i < 16) ? rnd[3:2] : i[1:0];
         unit_switch = rnd[5:4];
         stall = (o == `OP_WRITE);
         repeat (6) @(negedge core_clk);
         host.issue({unit_switch, o, hc}, ok);
         check("accepted", ok, 1);
         check("op code", cmd_code, o);
         check("set density", cmd_set_density, at_bot && o inside {4'h6, 4'h7});
         de = dens_exp(panel_density, hc, id_density);
         if (!(at_bot && o inside {4'h6, 4'h7}))
            de = id_density;
         check("density", cmd_density, de);
         traffic(o);
      end
      // Reset in mid-command, then a fresh command
      host.issue({unit_switch, `OP_REWIND, 2'h0}, ok);
      rstn = 1'b0;
      @(negedge core_clk);
      check("reset busy", busy, 0);
      rstn = 1'b1;
      repeat (6) @(negedge core_clk);
      host.issue({unit_switch, `OP_CLEAR, 2'h0}, ok);
      check("after reset", ok, 1);
      traffic(`OP_CLEAR);
      summarize();
   end
endmodule
